// ### rtl/prcb_reg_bank.sv
// RTC day and buck regulator configuration register bank, slots 0x16 to 0x1c
`timescale 1ns/1ps
module prcb_reg_bank #(
	parameter int DAY_W = prcb_pkg::DAY_W,
	parameter int ADDR_W = prcb_pkg::ADDR_W,
	parameter int DATA_W = prcb_pkg::DATA_W
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic rtc_power_on_reset,
	input wire logic global_reset_request,
	input wire logic system_reset_n,
	input wire logic off_state_reset_n,
	input wire logic startup_restore,
	input wire logic [3:0] power_up_strap,
	input wire logic day_rollover,
	input wire logic tod_alarm_match,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	output logic [DAY_W-1:0] day_count,
	output logic [DAY_W-1:0] day_compare_value,
	output logic day_alarm_event,
	output logic [5:0] buck_one_a_normal_setting,
	output logic [5:0] buck_one_a_standby_setting,
	output logic [5:0] buck_two_normal_setting,
	output logic [5:0] buck_two_standby_setting,
	output logic [4:0] buck_three_normal_setting,
	output logic [4:0] buck_three_standby_setting,
	output logic [4:0] buck_four_a_normal_setting,
	output logic [4:0] buck_four_a_standby_setting,
	output logic [1:0] buck_four_a_high_range,
	output logic [4:0] buck_four_b_normal_setting,
	output logic [4:0] buck_four_b_standby_setting,
	output logic [1:0] buck_four_b_high_range,
	output logic [4:0] buck_five_normal_setting,
	output logic [4:0] buck_five_standby_setting,
	output logic [3:0] buck_one_a_op_mode,
	output logic buck_one_a_memory_hold,
	output logic buck_one_a_user_off,
	output logic [1:0] buck_one_scaling_speed,
	output logic [3:0] buck_two_op_mode,
	output logic buck_two_memory_hold,
	output logic buck_two_user_off,
	output logic [1:0] buck_two_scaling_speed,
	output logic freq_synth_enable,
	output logic freq_synth_multiplier,
	output logic [3:0] latched_strap
);
	typedef struct packed {
		logic [14:0] day;
		logic [14:0] day_cmp;
		logic [5:0] b1n;
		logic [5:0] b1s;
		logic [5:0] b2n;
		logic [5:0] b2s;
		logic [4:0] b3n;
		logic [4:0] b3s;
		logic [4:0] b4an;
		logic [4:0] b4as;
		logic [1:0] b4ah;
		logic [4:0] b4bn;
		logic [4:0] b4bs;
		logic [1:0] b4bh;
		logic [4:0] b5n;
		logic [4:0] b5s;
		logic [3:0] m1;
		logic mh1;
		logic uo1;
		logic [1:0] sp1;
		logic [3:0] m2;
		logic mh2;
		logic uo2;
		logic [1:0] sp2;
		logic fse;
		logic fsm;
		logic [3:0] strap;
		logic [23:0] rdata;
		logic rvalid;
	} prcb_bank_state_t;

	prcb_bank_state_t st;
	prcb_bank_state_t next_st;
	logic sys_reset;

	prcb_alarm_if alarm_bus ();

	// The field map is fixed in the package, so only its widths can be served;
	// other values would leave fields cut off or bits undriven
	if (DAY_W != prcb_pkg::DAY_W) begin : g_bad_day_w
		$error("prcb_reg_bank: DAY_W must equal the day field width");
	end
	if (ADDR_W != prcb_pkg::ADDR_W) begin : g_bad_addr_w
		$error("prcb_reg_bank: ADDR_W must equal the register address width");
	end
	if (DATA_W != prcb_pkg::DATA_W) begin : g_bad_data_w
		$error("prcb_reg_bank: DATA_W must equal the register word width");
	end

	// Start-up mode default; every strap setting leaves the bucks in
	// auto pulse-skip, but the strap is kept as an argument so a new
	// strap table only touches this function
	function automatic logic [3:0] mode_default(input logic [3:0] strap);
		logic [3:0] m;
		m = prcb_pkg::AUTO_PULSE_SKIP_MODE;
		case (strap)
			default: begin
				m = prcb_pkg::AUTO_PULSE_SKIP_MODE;
			end
		endcase
		return m;
	endfunction : mode_default

	// Assemble a read word; unlisted bits stay at zero
	// Reserved bits have no storage, so a read-modify-write cannot set them
	function automatic logic [23:0] read_word(input prcb_bank_state_t s,
		input logic [5:0] a);
		logic [23:0] w;
		w = prcb_pkg::ZERO_WORD;
		case (a)
			prcb_pkg::A_DAY: begin
				w[prcb_pkg::DAY_LSB +: prcb_pkg::DAY_W] = s.day;
			end
			prcb_pkg::A_DAY_CMP: begin
				w[prcb_pkg::DAY_LSB +: prcb_pkg::DAY_W] = s.day_cmp;
			end
			prcb_pkg::A_B1: begin
				w[prcb_pkg::B1N_LSB +: prcb_pkg::W6] = s.b1n;
				w[prcb_pkg::B1S_LSB +: prcb_pkg::W6] = s.b1s;
			end
			prcb_pkg::A_B23: begin
				w[prcb_pkg::B2N_LSB +: prcb_pkg::W6] = s.b2n;
				w[prcb_pkg::B2S_LSB +: prcb_pkg::W6] = s.b2s;
				w[prcb_pkg::B3N_LSB +: prcb_pkg::W5] = s.b3n;
				w[prcb_pkg::B3S_LSB +: prcb_pkg::W5] = s.b3s;
			end
			prcb_pkg::A_B4: begin
				w[prcb_pkg::B4AN_LSB +: prcb_pkg::W5] = s.b4an;
				w[prcb_pkg::B4AS_LSB +: prcb_pkg::W5] = s.b4as;
				w[prcb_pkg::B4AH_LSB +: prcb_pkg::W2] = s.b4ah;
				w[prcb_pkg::B4BN_LSB +: prcb_pkg::W5] = s.b4bn;
				w[prcb_pkg::B4BS_LSB +: prcb_pkg::W5] = s.b4bs;
				w[prcb_pkg::B4BH_LSB +: prcb_pkg::W2] = s.b4bh;
			end
			prcb_pkg::A_B5: begin
				w[prcb_pkg::B5N_LSB +: prcb_pkg::W5] = s.b5n;
				w[prcb_pkg::B5S_LSB +: prcb_pkg::W5] = s.b5s;
			end
			prcb_pkg::A_MODE: begin
				w[prcb_pkg::M1_LSB +: prcb_pkg::W4] = s.m1;
				w[prcb_pkg::MH1_BIT] = s.mh1;
				w[prcb_pkg::UO1_BIT] = s.uo1;
				w[prcb_pkg::SP1_LSB +: prcb_pkg::W2] = s.sp1;
				w[prcb_pkg::M2_LSB +: prcb_pkg::W4] = s.m2;
				w[prcb_pkg::MH2_BIT] = s.mh2;
				w[prcb_pkg::UO2_BIT] = s.uo2;
				w[prcb_pkg::SP2_LSB +: prcb_pkg::W2] = s.sp2;
				w[prcb_pkg::FSE_BIT] = s.fse;
				w[prcb_pkg::FSM_BIT] = s.fsm;
			end
			default: begin
				w = prcb_pkg::ZERO_WORD;
			end
		endcase
		return w;
	endfunction : read_word

	// A global reset request acts as a system reset for the regulator side
	// The RTC fields are outside its reach and survive it
	assign sys_reset = !system_reset_n || global_reset_request;

	// Next state: counting, host access, then resets in rising priority
	// Later assignments win, so each reset overrides everything above it
	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;

		// Day advance from the time-of-day rollover
		if (day_rollover) begin
			next_st.day = 15'(st.day + 15'h0001);
		end

		// Host writes take only the documented fields
		// Unused bits have no flip-flop behind them, so writes to them vanish
		if (reg_wr) begin
			case (reg_addr)
				prcb_pkg::A_DAY: begin
					next_st.day = reg_wdata[prcb_pkg::DAY_LSB +: prcb_pkg::DAY_W];
				end
				prcb_pkg::A_DAY_CMP: begin
					next_st.day_cmp = reg_wdata[prcb_pkg::DAY_LSB +: prcb_pkg::DAY_W];
				end
				prcb_pkg::A_B1: begin
					next_st.b1n = reg_wdata[prcb_pkg::B1N_LSB +: prcb_pkg::W6];
					next_st.b1s = reg_wdata[prcb_pkg::B1S_LSB +: prcb_pkg::W6];
				end
				prcb_pkg::A_B23: begin
					next_st.b2n = reg_wdata[prcb_pkg::B2N_LSB +: prcb_pkg::W6];
					next_st.b2s = reg_wdata[prcb_pkg::B2S_LSB +: prcb_pkg::W6];
					next_st.b3n = reg_wdata[prcb_pkg::B3N_LSB +: prcb_pkg::W5];
					next_st.b3s = reg_wdata[prcb_pkg::B3S_LSB +: prcb_pkg::W5];
				end
				prcb_pkg::A_B4: begin
					next_st.b4an = reg_wdata[prcb_pkg::B4AN_LSB +: prcb_pkg::W5];
					next_st.b4as = reg_wdata[prcb_pkg::B4AS_LSB +: prcb_pkg::W5];
					next_st.b4ah = reg_wdata[prcb_pkg::B4AH_LSB +: prcb_pkg::W2];
					next_st.b4bn = reg_wdata[prcb_pkg::B4BN_LSB +: prcb_pkg::W5];
					next_st.b4bs = reg_wdata[prcb_pkg::B4BS_LSB +: prcb_pkg::W5];
					next_st.b4bh = reg_wdata[prcb_pkg::B4BH_LSB +: prcb_pkg::W2];
				end
				prcb_pkg::A_B5: begin
					next_st.b5n = reg_wdata[prcb_pkg::B5N_LSB +: prcb_pkg::W5];
					next_st.b5s = reg_wdata[prcb_pkg::B5S_LSB +: prcb_pkg::W5];
				end
				prcb_pkg::A_MODE: begin
					next_st.m1 = reg_wdata[prcb_pkg::M1_LSB +: prcb_pkg::W4];
					next_st.mh1 = reg_wdata[prcb_pkg::MH1_BIT];
					next_st.uo1 = reg_wdata[prcb_pkg::UO1_BIT];
					next_st.sp1 = reg_wdata[prcb_pkg::SP1_LSB +: prcb_pkg::W2];
					next_st.m2 = reg_wdata[prcb_pkg::M2_LSB +: prcb_pkg::W4];
					next_st.mh2 = reg_wdata[prcb_pkg::MH2_BIT];
					next_st.uo2 = reg_wdata[prcb_pkg::UO2_BIT];
					next_st.sp2 = reg_wdata[prcb_pkg::SP2_LSB +: prcb_pkg::W2];
					next_st.fse = reg_wdata[prcb_pkg::FSE_BIT];
					next_st.fsm = reg_wdata[prcb_pkg::FSM_BIT];
				end
				default: begin
					next_st.rvalid = 1'b0; // Unmapped writes are dropped
				end
			endcase
		end

		// Reads return the pre-write contents in the same cycle
		// The word is registered and stands until the next read
		if (reg_rd) begin
			next_st.rdata = read_word(st, reg_addr);
			next_st.rvalid = 1'b1;
		end

		// Sequencer restore of the operating modes from the strap
		if (startup_restore) begin
			next_st.strap = power_up_strap;
			next_st.m1 = mode_default(power_up_strap);
			next_st.m2 = mode_default(power_up_strap);
		end

		// Off-state reset clears only hold and user-off bits
		// Modes and settings are left for the system reset to handle
		if (!off_state_reset_n) begin
			next_st.mh1 = 1'b0;
			next_st.uo1 = 1'b0;
			next_st.mh2 = 1'b0;
			next_st.uo2 = 1'b0;
		end

		// System reset leaves the RTC fields and no-reset settings alone
		if (sys_reset) begin
			next_st.m1 = prcb_pkg::AUTO_PULSE_SKIP_MODE;
			next_st.sp1 = prcb_pkg::SPEED_RST;
			next_st.m2 = prcb_pkg::AUTO_PULSE_SKIP_MODE;
			next_st.sp2 = prcb_pkg::SPEED_RST;
			next_st.fse = prcb_pkg::FSE_RST;
			next_st.fsm = prcb_pkg::FSM_RST;
			next_st.b4bn[prcb_pkg::W5-1] = prcb_pkg::B4B_SET_RST[prcb_pkg::W5-1];
			next_st.b4bs = prcb_pkg::B4B_SET_RST;
			next_st.b4bh = prcb_pkg::B4B_HI_RST;
		end

		// Of the resets in this block, only the RTC power-on reset reaches the day fields
		if (rtc_power_on_reset) begin
			next_st.day = prcb_pkg::DAY_RST;
			next_st.day_cmp = prcb_pkg::DAY_CMP_RST;
		end
	end

	// Block reset gives every field, even no-reset settings, a known value
	// Only constants are loaded, so the reset path stays a plain mux
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '0;
			st.day_cmp <= prcb_pkg::DAY_CMP_RST;
			st.m1 <= prcb_pkg::AUTO_PULSE_SKIP_MODE;
			st.m2 <= prcb_pkg::AUTO_PULSE_SKIP_MODE;
			st.sp1 <= prcb_pkg::SPEED_RST;
			st.sp2 <= prcb_pkg::SPEED_RST;
			st.fse <= prcb_pkg::FSE_RST;
		end else begin
			st <= next_st;
		end
	end

	// Comparator sees the live day fields
	// so a host write of either field can raise the event next cycle
	assign alarm_bus.day_count = st.day;
	assign alarm_bus.day_compare_value = st.day_cmp;
	assign alarm_bus.tod_alarm_match = tod_alarm_match;

	prcb_day_alarm #(
		.DAY_W(DAY_W)
	) u_day_alarm (
		.sys_clk(sys_clk),
		.rst(rst),
		.alm(alarm_bus.alarm)
	);

	// Registered read word and valid pulse straight to the host port
	assign reg_rdata = st.rdata;
	assign reg_rvalid = st.rvalid;

	// Day fields and the alarm event
	assign day_count = st.day;
	assign day_compare_value = st.day_cmp;
	assign day_alarm_event = alarm_bus.day_alarm_event;

	// Buck voltage settings; most have no reset source of their own
	assign buck_one_a_normal_setting = st.b1n;
	assign buck_one_a_standby_setting = st.b1s;
	assign buck_two_normal_setting = st.b2n;
	assign buck_two_standby_setting = st.b2s;
	assign buck_three_normal_setting = st.b3n;
	assign buck_three_standby_setting = st.b3s;
	assign buck_four_a_normal_setting = st.b4an;
	assign buck_four_a_standby_setting = st.b4as;
	assign buck_four_a_high_range = st.b4ah;
	assign buck_four_b_normal_setting = st.b4bn;
	assign buck_four_b_standby_setting = st.b4bs;
	assign buck_four_b_high_range = st.b4bh;
	assign buck_five_normal_setting = st.b5n;
	assign buck_five_standby_setting = st.b5s;

	// Operating modes, scaling speeds and synthesiser controls
	assign buck_one_a_op_mode = st.m1;
	assign buck_one_a_memory_hold = st.mh1;
	assign buck_one_a_user_off = st.uo1;
	assign buck_one_scaling_speed = st.sp1;
	assign buck_two_op_mode = st.m2;
	assign buck_two_memory_hold = st.mh2;
	assign buck_two_user_off = st.uo2;
	assign buck_two_scaling_speed = st.sp2;
	assign freq_synth_enable = st.fse;
	assign freq_synth_multiplier = st.fsm;
	assign latched_strap = st.strap;
endmodule : prcb_reg_bank

// ### rtl/prcb_pkg.sv
// Constants for the RTC day and buck configuration register bank
// Operation
// - Day counter bits 0-14, RTC reset only
// - Day alarm bits 0-14, all ones default
// - Buck one normal setting bits 0-5
// - Buck one standby bits 6-11, rest reserved
// - Buck two normal setting bits 0-5
// - Buck two standby setting bits 6-11
// - Buck three normal bits 12-16, 17 zero
// - Buck three standby bits 18-22, 23 zero
// - Buck four A normal bits 0-4
// - Four A standby 5-9, high range 10-11
// - Four B normal 12-16, bit 16 system reset
// - Four B standby/high 17-23, system reset
// - Buck five normal bits 0-4, 5-9 unused
// - Buck five standby 10-14, 15-23 zero
// - Buck one mode/hold/off with their resets
// - Buck two mode/hold/off with their resets
// - Start-up restores modes to auto pulse-skip
package prcb_pkg;
	localparam int DAY_W = 15;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	// Register addresses
	localparam logic [5:0] A_DAY = 6'h16;
	localparam logic [5:0] A_DAY_CMP = 6'h17;
	localparam logic [5:0] A_B1 = 6'h18;
	localparam logic [5:0] A_B23 = 6'h19;
	localparam logic [5:0] A_B4 = 6'h1a;
	localparam logic [5:0] A_B5 = 6'h1b;
	localparam logic [5:0] A_MODE = 6'h1c;
	// Field widths
	localparam int W6 = 6;
	localparam int W5 = 5;
	localparam int W4 = 4;
	localparam int W2 = 2;
	// Field positions
	localparam int DAY_LSB = 0;
	localparam int B1N_LSB = 0;
	localparam int B1S_LSB = 6;
	localparam int B2N_LSB = 0;
	localparam int B2S_LSB = 6;
	localparam int B3N_LSB = 12;
	localparam int B3S_LSB = 18;
	localparam int B4AN_LSB = 0;
	localparam int B4AS_LSB = 5;
	localparam int B4AH_LSB = 10;
	localparam int B4BN_LSB = 12;
	localparam int B4BS_LSB = 17;
	localparam int B4BH_LSB = 22;
	localparam int B5N_LSB = 0;
	localparam int B5S_LSB = 10;
	localparam int M1_LSB = 0;
	localparam int MH1_BIT = 4;
	localparam int UO1_BIT = 5;
	localparam int SP1_LSB = 6;
	localparam int M2_LSB = 14;
	localparam int MH2_BIT = 18;
	localparam int UO2_BIT = 19;
	localparam int SP2_LSB = 20;
	localparam int FSE_BIT = 22;
	localparam int FSM_BIT = 23;
	// Reset values
	localparam logic [14:0] DAY_RST = 15'h0000;
	localparam logic [14:0] DAY_CMP_RST = 15'h7fff;
	localparam logic [3:0] AUTO_PULSE_SKIP_MODE = 4'h8;
	localparam logic [1:0] SPEED_RST = 2'h1;
	localparam logic FSE_RST = 1'b1;
	localparam logic FSM_RST = 1'b0;
	localparam logic [4:0] B4B_SET_RST = 5'h00;
	localparam logic [1:0] B4B_HI_RST = 2'h0;
	localparam logic [23:0] ZERO_WORD = 24'h00_0000;
endpackage : prcb_pkg

// ### rtl/prcb_alarm_if.sv
// Carrier between the register bank and the day alarm comparator
`timescale 1ns/1ps
interface prcb_alarm_if;
	logic [prcb_pkg::DAY_W-1:0] day_count;
	logic [prcb_pkg::DAY_W-1:0] day_compare_value;
	logic tod_alarm_match;
	logic day_alarm_event;
	modport bank (output day_count, output day_compare_value, output tod_alarm_match,
		input day_alarm_event);
	modport alarm (input day_count, input day_compare_value, input tod_alarm_match,
		output day_alarm_event);
endinterface : prcb_alarm_if

// ### rtl/prcb_day_alarm.sv
// Day alarm comparator producing a registered event that lasts as long as the qualified match
`timescale 1ns/1ps
module prcb_day_alarm #(
	parameter int DAY_W = prcb_pkg::DAY_W
) (
	input wire logic sys_clk,
	input wire logic rst,
	prcb_alarm_if.alarm alm
);
	typedef struct packed {
		logic fire;
	} prcb_alarm_state_t;

	prcb_alarm_state_t st;
	prcb_alarm_state_t next_st;

	// The comparator width must match the carrier
	if (DAY_W != prcb_pkg::DAY_W) begin : g_bad_width
		$error("prcb_day_alarm: DAY_W must equal the carrier width");
	end

	// Day match alone is not an alarm; the time-of-day match qualifies it
	always_comb begin
		next_st = st;
		next_st.fire = alm.tod_alarm_match
			&& (alm.day_count == alm.day_compare_value);
	end

	// Registered so the event is glitch-free and one cycle behind the qualified match
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign alm.day_alarm_event = st.fire;
endmodule : prcb_day_alarm

// ### tb/prcb_reg_bank_props.sv
// Port-level assertions for the configuration register bank
`timescale 1ns/1ps
module prcb_reg_bank_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic rtc_power_on_reset,
	input wire logic global_reset_request,
	input wire logic system_reset_n,
	input wire logic off_state_reset_n,
	input wire logic startup_restore,
	input wire logic [3:0] power_up_strap,
	input wire logic day_rollover,
	input wire logic tod_alarm_match,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [5:0] reg_addr,
	input wire logic [23:0] reg_rdata,
	input wire logic [14:0] day_count,
	input wire logic [14:0] day_compare_value,
	input wire logic day_alarm_event,
	input wire logic [4:0] buck_four_b_standby_setting,
	input wire logic [1:0] buck_four_b_high_range,
	input wire logic [3:0] buck_one_a_op_mode,
	input wire logic buck_one_a_memory_hold,
	input wire logic [3:0] buck_two_op_mode,
	input wire logic buck_two_user_off,
	input wire logic [3:0] latched_strap
);
	// Single domain, so one clock and one disable for all
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Steps that start a day alarm and a start-up restore
	sequence s_match;
		tod_alarm_match && (day_count == day_compare_value);
	endsequence
	sequence s_restore;
		startup_restore && system_reset_n && !global_reset_request;
	endsequence
	// Reset sources and their targets, then the restore, alarm event and unmapped read checks
	chk_day_rtc_reset: assert property (rtc_power_on_reset |=> day_count == 15'h0000)
		else $error("day count not cleared");
	chk_alarm_rtc_reset: assert property (rtc_power_on_reset
		|=> day_compare_value == 15'h7fff)
		else $error("day alarm not set to ones");
	chk_day_global_keep: assert property ((global_reset_request && !rtc_power_on_reset
		&& !reg_wr && !day_rollover) |=> $stable(day_count))
		else $error("day count lost on global reset");
	chk_mode_sys_reset: assert property ((!system_reset_n || global_reset_request)
		|=> buck_one_a_op_mode == 4'h8 && buck_two_op_mode == 4'h8)
		else $error("op mode not restored");
	chk_off_clears_hold: assert property (!off_state_reset_n
		|=> !buck_one_a_memory_hold && !buck_two_user_off)
		else $error("hold or user off not cleared");
	chk_b4b_sys_reset: assert property ((!system_reset_n || global_reset_request)
		|=> buck_four_b_standby_setting == 5'h00 && buck_four_b_high_range == 2'h0)
		else $error("buck four b fields not reset");
	chk_restore_modes: assert property (s_restore
		|=> buck_one_a_op_mode == 4'h8 && latched_strap == $past(power_up_strap))
		else $error("start-up restore missed");
	chk_alarm_event: assert property (s_match |=> day_alarm_event)
		else $error("day alarm event missing");
	chk_unmapped_zero: assert property ((reg_rd
		&& (reg_addr < 6'h16 || reg_addr > 6'h1c)) |=> reg_rdata == 24'h00_0000)
		else $error("unmapped read not zero");
endmodule : prcb_reg_bank_props

// ### tb/prcb_host_model.sv
// Host side register access model for the configuration bank
`timescale 1ns/1ps
module prcb_host_model (
	input wire logic sys_clk,
	input wire logic [23:0] reg_rdata,
	input wire logic reg_rvalid,
	output logic reg_wr,
	output logic reg_rd,
	output logic [5:0] reg_addr,
	output logic [23:0] reg_wdata
);
	// Bus idle at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 6'h00;
		reg_wdata = 24'h00_0000;
	end
	// Write held across one taking edge; data inverted after so stale data never matches
	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	// Read strobe, then data taken at the edge where the valid pulse is sampled
	task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic ok);
		int i;
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		ok = 1'b0;
		d = 24'h00_0000;
		for (i = 0; i < 4 && !ok; i++) begin
			@(posedge sys_clk);
			ok = (reg_rvalid === 1'b1);
			d = reg_rdata;
		end
	endtask : rd
endmodule : prcb_host_model

// ### tb/test_prcb_reg_bank.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module test_prcb_reg_bank;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic por = 1'b0;
	logic glb = 1'b0;
	logic sys_n = 1'b1;
	logic off_n = 1'b1;
	logic restore = 1'b0;
	logic [3:0] strap = 4'h0;
	logic roll = 1'b0;
	logic tod = 1'b0;
	logic wr, rd, rvalid, event_q;
	logic [5:0] addr;
	logic [23:0] wdata, rdata;
	logic [14:0] day;
	logic [3:0] lstrap;
	// Pin images packed without the registers' zero bits, checked against the written pattern
	wire [11:0] pb1;
	wire [21:0] pb23;
	wire [23:0] pb4;
	wire [9:0] pb5;
	wire [17:0] pmode;
	int fails = 0;
	int total_checks = 0;
	// Reset images and writable masks, slots 0x16 to 0x1c
	logic [23:0] rst_val [7] = '{24'h00_0000, 24'h00_7fff, 24'h00_0000, 24'h00_0000,
		24'h00_0000, 24'h00_0000, 24'h52_0048};
	logic [23:0] mask [7] = '{24'h00_7fff, 24'h00_7fff, 24'h00_0fff, 24'h7d_ffff,
		24'hff_ffff, 24'h00_7c1f, 24'hff_c0ff};
	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;
	prcb_host_model host (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
	prcb_reg_bank dut_u (.sys_clk(sys_clk), .rst(rst), .rtc_power_on_reset(por),
		.global_reset_request(glb), .system_reset_n(sys_n), .off_state_reset_n(off_n),
		.startup_restore(restore), .power_up_strap(strap), .day_rollover(roll),
		.tod_alarm_match(tod), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .day_count(day),
		.day_compare_value(), .day_alarm_event(event_q),
		.buck_one_a_normal_setting(pb1[5:0]), .buck_one_a_standby_setting(pb1[11:6]),
		.buck_two_normal_setting(pb23[5:0]), .buck_two_standby_setting(pb23[11:6]),
		.buck_three_normal_setting(pb23[16:12]), .buck_three_standby_setting(pb23[21:17]),
		.buck_four_a_normal_setting(pb4[4:0]), .buck_four_a_standby_setting(pb4[9:5]),
		.buck_four_a_high_range(pb4[11:10]), .buck_four_b_normal_setting(pb4[16:12]),
		.buck_four_b_standby_setting(pb4[21:17]), .buck_four_b_high_range(pb4[23:22]),
		.buck_five_normal_setting(pb5[4:0]), .buck_five_standby_setting(pb5[9:5]),
		.buck_one_a_op_mode(pmode[3:0]), .buck_one_a_memory_hold(pmode[4]),
		.buck_one_a_user_off(pmode[5]), .buck_one_scaling_speed(pmode[7:6]),
		.buck_two_op_mode(pmode[11:8]), .buck_two_memory_hold(pmode[12]),
		.buck_two_user_off(pmode[13]), .buck_two_scaling_speed(pmode[15:14]),
		.freq_synth_enable(pmode[16]), .freq_synth_multiplier(pmode[17]),
		.latched_strap(lstrap));
	task automatic wrap_up;
		if (fails == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Read one slot; a read that never answers ends the run
	task automatic rchk(input logic [5:0] a, input logic [23:0] exp);
		logic [23:0] d;
		logic ok;
		host.rd(a, d, ok);
		if (!ok) begin
			fails++;
			wrap_up();
		end else begin
			check(d, exp);
		end
	endtask : rchk
	task automatic t_defaults;
		for (int i = 0; i < 7; i++) begin
			rchk(prcb_pkg::A_DAY + 6'(i), rst_val[i]);
		end
		rchk(6'h15, 24'h00_0000);
	endtask : t_defaults
	// Two patterns so swapped field positions show up, ones last
	task automatic t_masks;
		logic [23:0] pat;
		logic [5:0] a;
		for (int j = 0; j < 2; j++) begin
			pat = (j == 0) ? 24'h5a_5a5a : 24'hff_ffff;
			for (int i = 0; i < 7; i++) begin
				a = prcb_pkg::A_DAY + 6'(i);
				host.wr(a, pat);
				rchk(a, pat & mask[i]);
			end
			check(24'(pb1), 24'(pat[11:0]));
			check(24'(pb23), 24'({pat[22:18], pat[16:0]}));
			check(pb4, pat);
			check(24'(pb5), 24'({pat[14:10], pat[4:0]}));
			check(24'(pmode), 24'({pat[23:14], pat[7:0]}));
		end
		host.wr(6'h1d, 24'hff_ffff);
		rchk(6'h1d, 24'h00_0000);
	endtask : t_masks
	task automatic t_off;
		@(posedge sys_clk);
		off_n <= 1'b0;
		@(posedge sys_clk);
		off_n <= 1'b1;
		rchk(prcb_pkg::A_MODE, 24'hf3_c0cf);
	endtask : t_off
	// Global request then system reset; RTC fields must survive both
	task automatic t_global;
		host.wr(prcb_pkg::A_DAY_CMP, 24'h00_0123);
		for (int k = 0; k < 2; k++) begin
			host.wr(prcb_pkg::A_B4, 24'hff_ffff);
			@(posedge sys_clk);
			glb <= (k == 0);
			sys_n <= (k == 0);
			@(posedge sys_clk);
			glb <= 1'b0;
			sys_n <= 1'b1;
			rchk(prcb_pkg::A_B4, 24'h00_ffff);
			rchk(prcb_pkg::A_MODE, 24'h52_0048);
			rchk(prcb_pkg::A_DAY, 24'h00_7fff);
			rchk(prcb_pkg::A_DAY_CMP, 24'h00_0123);
		end
	endtask : t_global
	task automatic t_rtc;
		@(posedge sys_clk);
		por <= 1'b1;
		@(posedge sys_clk);
		por <= 1'b0;
		rchk(prcb_pkg::A_DAY, 24'h00_0000);
		rchk(prcb_pkg::A_DAY_CMP, 24'h00_7fff);
	endtask : t_rtc
	task automatic t_restore;
		host.wr(prcb_pkg::A_MODE, 24'h00_0000);
		@(posedge sys_clk);
		strap <= 4'h9;
		restore <= 1'b1;
		@(posedge sys_clk);
		restore <= 1'b0;
		#1;
		check({20'h0_0000, lstrap}, 24'h00_0009);
		rchk(prcb_pkg::A_MODE, 24'h02_0008);
	endtask : t_restore
	// Rollover into a match, a near miss, and a wrap
	task automatic t_alarm;
		host.wr(prcb_pkg::A_DAY, 24'h00_0010);
		host.wr(prcb_pkg::A_DAY_CMP, 24'h00_0011);
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			roll <= (k == 0);
			@(posedge sys_clk);
			roll <= 1'b0;
			tod <= 1'b1;
			@(posedge sys_clk);
			tod <= 1'b0;
			#1;
			check({9'h000, day}, 24'h00_0011);
			check({23'h00_0000, event_q}, {23'h00_0000, k == 0});
			host.wr(prcb_pkg::A_DAY_CMP, 24'h00_0012);
		end
		host.wr(prcb_pkg::A_DAY, 24'h00_7fff);
		@(posedge sys_clk);
		roll <= 1'b1;
		@(posedge sys_clk);
		roll <= 1'b0;
		#1;
		check({9'h000, day}, 24'h00_0000);
	endtask : t_alarm
	// Main sequence
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		t_defaults();
		t_masks();
		t_off();
		t_global();
		t_rtc();
		t_restore();
		t_alarm();
		wrap_up();
	end
endmodule : test_prcb_reg_bank
bind prcb_reg_bank prcb_reg_bank_props u_props (.sys_clk(sys_clk), .rst(rst),
	.rtc_power_on_reset(rtc_power_on_reset), .global_reset_request(global_reset_request),
	.system_reset_n(system_reset_n), .off_state_reset_n(off_state_reset_n),
	.startup_restore(startup_restore), .power_up_strap(power_up_strap),
	.day_rollover(day_rollover), .tod_alarm_match(tod_alarm_match), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .day_count(day_count),
	.day_compare_value(day_compare_value), .day_alarm_event(day_alarm_event),
	.buck_four_b_standby_setting(buck_four_b_standby_setting),
	.buck_four_b_high_range(buck_four_b_high_range), .buck_one_a_op_mode(buck_one_a_op_mode),
	.buck_one_a_memory_hold(buck_one_a_memory_hold), .buck_two_op_mode(buck_two_op_mode),
	.buck_two_user_off(buck_two_user_off), .latched_strap(latched_strap));
